// >>> rtl/mcp_pkg.sv
// constants, types and helper functions for the module configuration parameter store
`default_nettype none
package mcp_pkg;

  localparam logic [7:0] CMD_SLEEP_SELECT = 8'h01;
  localparam logic [7:0] CMD_INACTIVITY   = 8'h02;
  localparam logic [7:0] CMD_HANDSHAKE    = 8'h16;
  localparam logic [7:0] CMD_SIGNAL_LEVEL = 8'h1c;
  localparam logic [7:0] CMD_SERIAL_UPPER = 8'h25;
  localparam logic [7:0] CMD_SERIAL_LOWER = 8'h26;
  localparam logic [7:0] CMD_STOP_BITS    = 8'h36;

  localparam logic [7:0] SLEEP_OFF       = 8'h00;
  localparam logic [7:0] SLEEP_PIN       = 8'h01;
  localparam logic [7:0] SLEEP_CYCLE_MIN = 8'h03;
  localparam logic [7:0] SLEEP_CYCLE_MAX = 8'h08;

  localparam logic [15:0] INACTIVITY_MIN   = 16'h0010;
  localparam logic [15:0] INACTIVITY_RESET = 16'h0064;

  localparam logic [7:0] HANDSHAKE_OFF   = 8'h00;
  localparam logic [7:0] HANDSHAKE_PROG  = 8'h01;
  localparam logic [7:0] HANDSHAKE_RTS   = 8'h02;
  localparam logic [7:0] STOP_BITS_ONE   = 8'h00;
  localparam logic [7:0] STOP_BITS_TWO   = 8'h01;

  localparam logic [7:0] LEVEL_MIN = 8'h06;
  localparam logic [7:0] LEVEL_MAX = 8'h36;

  localparam int CLOCK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_MS  = 100;
  localparam int TICK_CYCLES     = TICK_PERIOD_MS * 1000000 / CLOCK_PERIOD_NS;
  localparam int CYCLE_BASE_MS   = 500;
  localparam int CYCLE_BASE_TICKS = CYCLE_BASE_MS / TICK_PERIOD_MS;
  localparam logic [15:0] WAKE_WINDOW_TICKS = 16'h0001;

  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } mcp_cmd_s;

  typedef struct packed {
    logic        reject;
    logic        twoBytes;
    logic [15:0] data;
  } mcp_rsp_s;

  typedef enum logic [4:0] {
    S_AWAKE     = 5'b00001,
    S_PIN_SLEEP = 5'b00010,
    S_CYC_SLEEP = 5'b00100,
    S_LISTEN    = 5'b01000,
    S_SYNC      = 5'b10000
  } mcp_state_e;

  function automatic logic mcp_is_cyclic(input logic [7:0] mode);
    return (mode >= SLEEP_CYCLE_MIN) && (mode <= SLEEP_CYCLE_MAX);
  endfunction : mcp_is_cyclic

  // period doubles with each setting above the first cyclic one
  function automatic logic [15:0] mcp_cycle_ticks(input logic [7:0] mode);
    logic [7:0] step;
    step = mode - SLEEP_CYCLE_MIN;
    return 16'(CYCLE_BASE_TICKS) << step[2:0];
  endfunction : mcp_cycle_ticks

endpackage : mcp_pkg
`default_nettype wire

// >>> rtl/mcp_tick_counter.sv
// 100 ms tick divider and saturating tick counter with restart
`default_nettype none
module mcp_tick_counter
  import mcp_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        restart,
  output var  logic        tick,
  output var  logic [15:0] ticks
);

  logic [31:0] divider;

  // divider free-runs so restarts do not stretch the tick grid
  always_ff @(posedge clock) begin
    if (rst) begin
      divider <= 32'h0000_0000;
      tick    <= 1'b0;
    end else if (divider == 32'(TICKS - 1)) begin
      divider <= 32'h0000_0000;
      tick    <= 1'b1;
    end else begin
      divider <= divider + 32'h0000_0001;
      tick    <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || restart) begin
      ticks <= 16'h0000;
    end else if (tick && ticks != 16'hffff) begin
      ticks <= ticks + 16'h0001;
    end
  end

endmodule : mcp_tick_counter
`default_nettype wire

// >>> rtl/mcp_param_store.sv
// configuration parameter store, command answers and sleep sequencing
`default_nettype none
module mcp_param_store
  import mcp_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        cmdValid,
  input  wire mcp_cmd_s    cmd,
  output var  logic        rspValid,
  output var  mcp_rsp_s    rsp,
  input  wire logic        packetValid,
  input  wire logic [7:0]  packetLevel,
  input  wire logic [31:0] serialNumber,
  input  wire logic        linkActivity,
  input  wire logic        sleepPin,
  input  wire logic        initDetect,
  input  wire logic        initDone,
  output var  logic [7:0]  sleepSelect,
  output var  logic [15:0] inactivityTimeout,
  output var  logic [7:0]  handshakeLineConfig,
  output var  logic [7:0]  uartStopBitCount,
  output var  logic        twoStopBits,
  output var  logic        rtsFlowEnable,
  output var  logic        binaryProgEnable,
  output var  logic        sleeping,
  output var  logic        receiveSync
);

  mcp_state_e  state;
  mcp_state_e  next_state;
  logic [7:0]  receivedSignalLevel;
  logic [15:0] ticks;
  logic        restart;
  logic        cyclic;
  logic        writeOk;

  assign cyclic = mcp_is_cyclic(sleepSelect);

  always_comb begin
    writeOk = 1'b0;
    if (cmd.code == CMD_SLEEP_SELECT) begin
      writeOk = (cmd.data[15:8] == 8'h00) &&
                (cmd.data[7:0] <= SLEEP_PIN || mcp_is_cyclic(cmd.data[7:0]));
    end else if (cmd.code == CMD_INACTIVITY) begin
      writeOk = cmd.data >= INACTIVITY_MIN;
    end else if (cmd.code == CMD_HANDSHAKE) begin
      writeOk = (cmd.data[15:8] == 8'h00) && (cmd.data[7:0] <= HANDSHAKE_RTS);
    end else if (cmd.code == CMD_STOP_BITS) begin
      writeOk = (cmd.data[15:8] == 8'h00) && (cmd.data[7:0] <= STOP_BITS_TWO);
    end
  end

  // stored parameters; read-only codes and bad values never reach storage
  always_ff @(posedge clock) begin
    if (rst) begin
      sleepSelect         <= SLEEP_OFF;
      inactivityTimeout   <= INACTIVITY_RESET;
      handshakeLineConfig <= HANDSHAKE_OFF;
      uartStopBitCount    <= STOP_BITS_ONE;
    end else if (cmdValid && cmd.write && writeOk) begin
      if (cmd.code == CMD_SLEEP_SELECT) begin
        sleepSelect <= cmd.data[7:0];
      end else if (cmd.code == CMD_INACTIVITY) begin
        inactivityTimeout <= cmd.data;
      end else if (cmd.code == CMD_HANDSHAKE) begin
        handshakeLineConfig <= cmd.data[7:0];
      end else if (cmd.code == CMD_STOP_BITS) begin
        uartStopBitCount <= cmd.data[7:0];
      end
    end
  end

  // clamp keeps a noisy measurement inside the reportable span
  always_ff @(posedge clock) begin
    if (rst) begin
      receivedSignalLevel <= LEVEL_MIN;
    end else if (packetValid) begin
      if (packetLevel < LEVEL_MIN) begin
        receivedSignalLevel <= LEVEL_MIN;
      end else if (packetLevel > LEVEL_MAX) begin
        receivedSignalLevel <= LEVEL_MAX;
      end else begin
        receivedSignalLevel <= packetLevel;
      end
    end
  end

  // one answer per command, one cycle after it is taken
  always_ff @(posedge clock) begin
    if (rst) begin
      rspValid <= 1'b0;
      rsp      <= '0;
    end else begin
      rspValid     <= cmdValid;
      rsp.reject   <= 1'b0;
      rsp.twoBytes <= 1'b0;
      rsp.data     <= 16'h0000;
      if (cmdValid) begin
        if (cmd.code == CMD_SIGNAL_LEVEL) begin
          rsp.data   <= {8'h00, receivedSignalLevel};
          rsp.reject <= cmd.write;
        end else if (cmd.code == CMD_SERIAL_UPPER) begin
          rsp.data     <= serialNumber[31:16];
          rsp.twoBytes <= 1'b1;
          rsp.reject   <= cmd.write;
        end else if (cmd.code == CMD_SERIAL_LOWER) begin
          rsp.data     <= serialNumber[15:0];
          rsp.twoBytes <= 1'b1;
          rsp.reject   <= cmd.write;
        end else if (cmd.code == CMD_SLEEP_SELECT) begin
          rsp.data   <= {8'h00, sleepSelect};
          rsp.reject <= cmd.write && !writeOk;
        end else if (cmd.code == CMD_INACTIVITY) begin
          rsp.data     <= inactivityTimeout;
          rsp.twoBytes <= 1'b1;
          rsp.reject   <= cmd.write && !writeOk;
        end else if (cmd.code == CMD_HANDSHAKE) begin
          rsp.data   <= {8'h00, handshakeLineConfig};
          rsp.reject <= cmd.write && !writeOk;
        end else if (cmd.code == CMD_STOP_BITS) begin
          rsp.data   <= {8'h00, uartStopBitCount};
          rsp.reject <= cmd.write && !writeOk;
        end else begin
          rsp.reject <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      S_AWAKE: begin
        if (sleepSelect == SLEEP_PIN && sleepPin) begin
          next_state = S_PIN_SLEEP;
        end else if (cyclic && ticks >= inactivityTimeout) begin
          next_state = S_CYC_SLEEP;
        end
      end
      S_PIN_SLEEP: begin
        if (sleepSelect != SLEEP_PIN || !sleepPin) begin
          next_state = S_AWAKE;
        end
      end
      S_CYC_SLEEP: begin
        if (!cyclic) begin
          next_state = S_AWAKE;
        end else if (ticks >= mcp_cycle_ticks(sleepSelect)) begin
          next_state = S_LISTEN;
        end
      end
      S_LISTEN: begin
        if (!cyclic) begin
          next_state = S_AWAKE;
        end else if (initDetect) begin
          next_state = S_SYNC;
        end else if (ticks >= WAKE_WINDOW_TICKS) begin
          next_state = S_CYC_SLEEP;
        end
      end
      S_SYNC: begin
        if (initDone) begin
          next_state = S_AWAKE;
        end
      end
      default: begin
        next_state = S_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state       <= S_AWAKE;
      sleeping    <= 1'b0;
      receiveSync <= 1'b0;
    end else begin
      state       <= next_state;
      sleeping    <= (next_state == S_PIN_SLEEP) || (next_state == S_CYC_SLEEP);
      receiveSync <= next_state == S_SYNC;
    end
  end

  // every state change also restarts timing of the new phase
  assign restart = (state == S_AWAKE && linkActivity) || (next_state != state);

  mcp_tick_counter #(
    .TICKS (TICKS)
  ) tickCounter (
    .clock   (clock),
    .rst     (rst),
    .restart (restart),
    .tick    (),
    .ticks   (ticks)
  );

  assign twoStopBits      = uartStopBitCount == STOP_BITS_TWO;
  assign rtsFlowEnable    = handshakeLineConfig == HANDSHAKE_RTS;
  assign binaryProgEnable = handshakeLineConfig == HANDSHAKE_PROG;

endmodule : mcp_param_store
`default_nettype wire

// >>> verification/mcp_param_store_checker.sv
// assertions on the configuration parameter store ports
`default_nettype none
module mcp_param_store_checker
  import mcp_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        cmdValid,
  input wire mcp_cmd_s    cmd,
  input wire logic        rspValid,
  input wire mcp_rsp_s    rsp,
  input wire logic [31:0] serialNumber,
  input wire logic        sleepPin,
  input wire logic [7:0]  sleepSelect,
  input wire logic [7:0]  handshakeLineConfig,
  input wire logic [7:0]  uartStopBitCount,
  input wire logic        twoStopBits,
  input wire logic        rtsFlowEnable,
  input wire logic        binaryProgEnable,
  input wire logic        sleeping
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_rd(logic [7:0] c);
    cmdValid && !cmd.write && cmd.code == c;
  endsequence
  sequence s_wr;
    cmdValid && cmd.write;
  endsequence
  property p_ans; rspValid == $past(cmdValid); endproperty
  a_ans: assert property (p_ans) else $error("answer strobe");
  property p_lvl;
    s_rd(CMD_SIGNAL_LEVEL) |=> !rsp.reject && rsp.data inside {[16'h0006:16'h0036]};
  endproperty
  a_lvl: assert property (p_lvl) else $error("level range");
  property p_up; s_rd(CMD_SERIAL_UPPER) |=> rsp.twoBytes && rsp.data == serialNumber[31:16];
  endproperty
  a_up: assert property (p_up) else $error("serial upper");
  property p_lo; s_rd(CMD_SERIAL_LOWER) |=> rsp.twoBytes && rsp.data == serialNumber[15:0];
  endproperty
  a_lo: assert property (p_lo) else $error("serial lower");
  property p_ro; s_wr ##0 cmd.code inside {8'h1c, 8'h25, 8'h26} |=> rsp.reject; endproperty
  a_ro: assert property (p_ro) else $error("read-only write");
  property p_sm;
    s_wr ##0 cmd.code == CMD_SLEEP_SELECT
      && !(cmd.data inside {16'h0000, 16'h0001, [16'h0003:16'h0008]})
      |=> rsp.reject && $stable(sleepSelect);
  endproperty
  a_sm: assert property (p_sm) else $error("sleep range");
  property p_dec;
    twoStopBits == (uartStopBitCount == 8'h01) && rtsFlowEnable == (handshakeLineConfig == 8'h02)
      && binaryProgEnable == (handshakeLineConfig == 8'h01);
  endproperty
  a_dec: assert property (p_dec) else $error("decodes");
  property p_off; (sleepSelect == 8'h00)[*3] |-> !sleeping; endproperty
  a_off: assert property (p_off) else $error("sleep while off");
  property p_pin; (sleepSelect == 8'h01)[*2] |-> sleeping == $past(sleepPin); endproperty
  a_pin: assert property (p_pin) else $error("pin sleep");
  // bound holds for TICKS of 4: 5 ticks asleep plus one tick of grid jitter
  property p_wake; $rose(sleeping) && sleepSelect == 8'h03 |-> ##[1:30] !sleeping; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
endmodule : mcp_param_store_checker
bind mcp_param_store mcp_param_store_checker #(.TICKS(TICKS)) chk (
  .clock(clock), .rst(rst), .cmdValid(cmdValid), .cmd(cmd), .rspValid(rspValid), .rsp(rsp),
  .serialNumber(serialNumber), .sleepPin(sleepPin), .sleepSelect(sleepSelect),
  .handshakeLineConfig(handshakeLineConfig), .uartStopBitCount(uartStopBitCount),
  .twoStopBits(twoStopBits), .rtsFlowEnable(rtsFlowEnable),
  .binaryProgEnable(binaryProgEnable), .sleeping(sleeping)
);
`default_nettype wire

// >>> verification/mcp_host_model.sv
// host issuing binary configuration commands one at a time
`default_nettype none
module mcp_host_model
  import mcp_pkg::*;
(
  input  wire logic     clock,
  output var  logic     cmdValid,
  output var  mcp_cmd_s cmd,
  input  wire logic     rspValid,
  input  wire mcp_rsp_s rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmdValid = 1'b0;
    cmd = '0;
  end
  // answer stands one cycle only, so it is taken right after the taking edge
  task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output mcp_rsp_s r);
    @(posedge clock);
    cmdValid <= 1'b1;
    cmd <= '{write: w, code: c, data: d};
    @(posedge clock);
    cmdValid <= 1'b0;
    cmd <= ~cmd;
    #1;
    r = rspValid ? rsp : '1;
  endtask : send
endmodule : mcp_host_model
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the configuration parameter store
`default_nettype none
module tb
  import mcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] SERIAL = 32'h5a3c_e187;
  logic clock, rst, cmdValid, rspValid, packetValid, linkActivity, sleepPin, initDetect, initDone;
  logic twoStopBits, rtsFlowEnable, binaryProgEnable, sleeping, receiveSync;
  logic [7:0] packetLevel, sleepSelect, handshakeLineConfig, uartStopBitCount;
  logic [15:0] inactivityTimeout;
  mcp_cmd_s cmd;
  mcp_rsp_s rsp, r;
  int nFail = 0;
  int numChecks = 0;
  mcp_param_store #(.TICKS(4)) uut (
    .clock(clock), .rst(rst), .cmdValid(cmdValid), .cmd(cmd), .rspValid(rspValid), .rsp(rsp),
    .packetValid(packetValid), .packetLevel(packetLevel), .serialNumber(SERIAL),
    .linkActivity(linkActivity), .sleepPin(sleepPin), .initDetect(initDetect),
    .initDone(initDone), .sleepSelect(sleepSelect), .inactivityTimeout(inactivityTimeout),
    .handshakeLineConfig(handshakeLineConfig), .uartStopBitCount(uartStopBitCount),
    .twoStopBits(twoStopBits), .rtsFlowEnable(rtsFlowEnable),
    .binaryProgEnable(binaryProgEnable), .sleeping(sleeping), .receiveSync(receiveSync));
  mcp_host_model host (.clock(clock), .cmdValid(cmdValid), .cmd(cmd), .rspValid(rspValid),
    .rsp(rsp));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("unexpected %s: expected %h, seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    host.send(1'b0, c, 16'h0, r);
    chk("read data", r.data, exp);
  endtask : rd
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic rej);
    host.send(1'b1, c, d, r);
    chk("reject", 16'(r.reject), 16'(rej));
  endtask : wr
  // waits for sleeping (s=0) or receiveSync (s=1) to reach v
  task automatic waitFor(input bit s, input logic v);
    for (int i = 0; i < 200 && (s ? receiveSync : sleeping) !== v; i++) begin
      @(posedge clock);
      #1;
    end
    chk(s ? "sync" : "sleeping", 16'(s ? receiveSync : sleeping), 16'(v));
  endtask : waitFor
  task automatic testParams();
    logic [7:0] lv[3] = '{8'h50, 8'h01, 8'h20};
    logic [7:0] ex[3] = '{8'h36, 8'h06, 8'h20};
    rd(CMD_SLEEP_SELECT, 16'h0);
    rd(CMD_INACTIVITY, 16'h64);
    rd(CMD_HANDSHAKE, 16'h0);
    rd(CMD_STOP_BITS, 16'h0);
    wr(CMD_STOP_BITS, 16'h1, 1'b0);
    wr(CMD_STOP_BITS, 16'h2, 1'b1);
    rd(CMD_STOP_BITS, 16'h1);
    chk("two stop", 16'(twoStopBits), 16'h1);
    chk("stop bit port", 16'(uartStopBitCount), 16'h1);
    wr(CMD_HANDSHAKE, 16'h2, 1'b0);
    chk("rts", 16'(rtsFlowEnable), 16'h1);
    wr(CMD_HANDSHAKE, 16'h1, 1'b0);
    chk("prog", 16'(binaryProgEnable), 16'h1);
    wr(CMD_HANDSHAKE, 16'h3, 1'b1);
    rd(CMD_HANDSHAKE, 16'h1);
    chk("handshake port", 16'(handshakeLineConfig), 16'h1);
    for (int m = 9; m >= 0; m--) begin
      wr(CMD_SLEEP_SELECT, 16'(m), m == 2 || m == 9);
    end
    rd(CMD_SLEEP_SELECT, 16'h0);
    chk("select port", 16'(sleepSelect), 16'h0);
    wr(CMD_INACTIVITY, 16'h000f, 1'b1);
    wr(CMD_INACTIVITY, 16'h0010, 1'b0);
    rd(CMD_INACTIVITY, 16'h0010);
    chk("timeout port", inactivityTimeout, 16'h0010);
    wr(8'h7f, 16'h0, 1'b1);
    wr(CMD_SIGNAL_LEVEL, 16'h0, 1'b1);
    wr(CMD_SERIAL_UPPER, 16'h0, 1'b1);
    wr(CMD_SERIAL_LOWER, 16'h0, 1'b1);
    rd(CMD_SERIAL_UPPER, SERIAL[31:16]);
    rd(CMD_SERIAL_LOWER, SERIAL[15:0]);
    rd(CMD_SIGNAL_LEVEL, 16'h06);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      packetValid <= 1'b1;
      packetLevel <= lv[i];
      @(posedge clock);
      packetValid <= 1'b0;
      packetLevel <= ~lv[i];
      rd(CMD_SIGNAL_LEVEL, 16'(ex[i]));
    end
  endtask : testParams
  task automatic testSleep();
    wr(CMD_SLEEP_SELECT, 16'(SLEEP_PIN), 1'b0);
    @(posedge clock);
    sleepPin <= 1'b1;
    waitFor(0, 1'b1);
    @(posedge clock);
    sleepPin <= 1'b0;
    waitFor(0, 1'b0);
    wr(CMD_SLEEP_SELECT, 16'h3, 1'b0);
    repeat (100) begin
      @(posedge clock);
      linkActivity <= ~linkActivity;
    end
    @(posedge clock);
    linkActivity <= 1'b0;
    // look after the edge so the flop has settled
    #1;
    chk("busy awake", 16'(sleeping), 16'h0);
    waitFor(0, 1'b1);
    waitFor(0, 1'b0);
    waitFor(0, 1'b1);
    @(posedge clock);
    initDetect <= 1'b1;
    waitFor(1, 1'b1);
    chk("awake in sync", 16'(sleeping), 16'h0);
    @(posedge clock);
    initDetect <= 1'b0;
    initDone <= 1'b1;
    waitFor(1, 1'b0);
    @(posedge clock);
    initDone <= 1'b0;
    wr(CMD_SLEEP_SELECT, 16'(SLEEP_OFF), 1'b0);
  endtask : testSleep
  task automatic giveVerdict();
    if (nFail == 0 && numChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : giveVerdict
  initial begin
    repeat (3000) @(posedge clock);
    nFail++;
    giveVerdict();
  end
  initial begin
    {rst, packetValid, packetLevel, linkActivity, sleepPin, initDetect, initDone} = '1;
    repeat (6) @(posedge clock);
    {rst, packetValid, linkActivity, sleepPin, initDetect, initDone} <= '0;
    testParams();
    testSleep();
    giveVerdict();
  end
endmodule : tb
`default_nettype wire
